// *** logic/ccfm_pkg.sv ***
// Constants and types for the count channel with comparator and frequency meter.
// Assumes a single APB clock domain at the rate below.
package ccfm_pkg;

  // Clock and time base
  localparam int CLK_HZ         = 10_000_000;
  localparam int MS_TICK_US     = 1000;
  localparam int CYC_PER_MS     = (CLK_HZ / 1_000_000) * MS_TICK_US;
  localparam int PRE_W          = 16;
  localparam int PULSE_STEP_MS  = 2;
  localparam int PULSE_MS_MAX   = 510;
  localparam int ITIME_MS_MIN   = 10;
  localparam int ITIME_MS_MAX   = 10000;
  localparam logic [63:0] MHZ_PER_EDGE_MS = 64'h0000_0000_000F_4240;

  // Register byte addresses
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CMP    = 12'h008;
  localparam logic [11:0] OFS_LOAD   = 12'h00C;
  localparam logic [11:0] OFS_HYST   = 12'h010;
  localparam logic [11:0] OFS_PDUR   = 12'h014;
  localparam logic [11:0] OFS_ITIME  = 12'h018;
  localparam logic [11:0] OFS_COUNT  = 12'h01C;
  localparam logic [11:0] OFS_LATCH  = 12'h020;
  localparam logic [11:0] OFS_MEAS   = 12'h024;

  // Control field positions
  localparam int CTL_SOFTWARE_GATE_BIT  = 0;
  localparam int CTL_HW_EN    = 1;
  localparam int CTL_STOP_FN  = 2;
  localparam int CTL_SINGLE   = 3;
  localparam int CTL_MODE_LO  = 4;
  localparam int CTL_DIR_LO   = 6;
  localparam int CTL_OUT_EN   = 8;
  localparam int CTL_CTRL_DO  = 9;
  localparam int CTL_FREQ     = 10;
  localparam int CTL_MEAS_IE  = 11;
  localparam int CTL_CMP_IE   = 12;
  localparam int CTL_W        = 13;

  // Status field positions
  localparam int COMPARE_STATUS_FLAG_POS  = 0;
  localparam int STS_OUT_POS  = 1;
  localparam int STS_GATE_POS = 2;
  localparam int STS_AUTO_POS = 3;

  // Reset values
  localparam logic [CTL_W-1:0] CTRL_RST  = 13'h0004;
  localparam logic [13:0]      ITIME_RST = 14'h0064;
  localparam logic [31:0]      ZERO32    = 32'h0000_0000;

  // Synchronised pin positions
  localparam int PIN_PULSE = 0;
  localparam int PIN_DIR   = 1;
  localparam int PIN_HWG   = 2;
  localparam int PIN_LATCH = 3;

  typedef enum logic [1:0] {CMP_NONE, CMP_GE, CMP_LE, CMP_PULSE} ccfm_mode_t;
  typedef enum logic [1:0] {DIR_ANY, DIR_UP, DIR_DOWN, DIR_RSVD} ccfm_dir_t;

  typedef struct packed {
    logic [3:0]       s1;
    logic [3:0]       s2;
    logic [3:0]       sp;
    logic [CTL_W-1:0] ctrl;
    logic [31:0]      cmp;
    logic [31:0]      load;
    logic [7:0]       hyst;
    logic [7:0]       pdur;
    logic [13:0]      itime;
    logic [31:0]      count;
    logic [31:0]      latch;
    logic [31:0]      meas;
    logic             gate;
    logic             auto_closed;
    logic             hw_rise_seen;
    logic             sw_prev;
    logic             last_up;
    logic             result;
    logic             do_out;
    logic             cmp_flag;
    logic             clr_pend;
    logic             hyst_act;
    logic             hyst_up;
    logic [31:0]      hyst_lo;
    logic [31:0]      hyst_hi;
    logic             pulse_run;
    logic [9:0]       pulse_ms;
    logic [PRE_W-1:0] pre;
    logic [13:0]      int_ms;
    logic [13:0]      int_len;
    logic [31:0]      edges;
    logic             meas_irq;
    logic             cmp_irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } ccfm_state_t;

endpackage : ccfm_pkg

// *** logic/ccfm_top.sv ***
// Count channel extras: gate control, latch, comparator with pulse and hysteresis,
// and frequency measurement, with an APB register file.
// Assumes field pins are asynchronous and pass a two-stage synchroniser first.
//
// Contract
// RULE1: Stop gate resumes from held count.
// RULE2: Single-count reopen needs hardware gate edge.
// RULE3: Latch edge copies count while counting.
// RULE4: Latched value kept across stop-run.
// RULE5: One comparison value drives output and flag.
// RULE6: No comparison: plain output, flags cleared.
// RULE7: Greater/less-equal holds output while true.
// RULE8: Flag clear waits for condition or pulse.
// RULE9: Pulse at hit, main direction only.
// RULE10: Zero duration follows the comparison condition.
// RULE11: Duration 0-510 ms, 2 ms steps.
// RULE12: Running pulse never retriggered or extended.
// RULE13: New duration applies from next pulse.
// RULE14: Hysteresis width 0-255, 0/1 off.
// RULE15: Width change waits for next activation.
// RULE16: Hit activates band, freezes result until left.
// RULE17: Leaving band against direction emits pulse.
// RULE18: Count pulses over 10-10000 ms window.
// RULE19: Result updated per period, zero without edges.
// RULE20: Result given in millihertz.
// RULE21: Max frequency independent of channel count.
// RULE22: Frequency mode disables ordinary counting.
// RULE23: Internal gate combines hardware and software gate; frequency measurement uses the software gate only.
// RULE24: End-of-measurement interrupt each period.
// RULE25: Millihertz equals edges times million over ms.
// RULE26: Inputs sampled, edges from consecutive samples.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ccfm_top
  import ccfm_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Field inputs
  input  wire logic        pulse_in,
  input  wire logic        dir_in,
  input  wire logic        hardware_gate_input,
  input  wire logic        latch_in,
  // Field output and events
  output logic             digital_out,
  output logic             output_state_indication,
  output logic             cmp_irq,
  output logic             meas_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_CMP) || (a == OFS_LOAD) ||
                 (a == OFS_HYST) || (a == OFS_PDUR) || (a == OFS_ITIME) || (a == OFS_COUNT) ||
                 (a == OFS_LATCH) || (a == OFS_MEAS);
  endfunction : addr_known

  function automatic logic [31:0] freq_mhz(input logic [31:0] edges, input logic [13:0] t_ms);
    logic [63:0] prod;
    prod = {32'h0000_0000, edges} * MHZ_PER_EDGE_MS;
    if (t_ms == 14'h0000) begin
      freq_mhz = ZERO32;
    end else begin
      freq_mhz = 32'(prod / {50'h0, t_ms});
    end
  endfunction : freq_mhz

  function automatic logic [31:0] status_word(input ccfm_state_t s);
    status_word = ZERO32;
    status_word[COMPARE_STATUS_FLAG_POS]  = s.cmp_flag;
    status_word[STS_OUT_POS]  = s.do_out & (s.ctrl[CTL_MODE_LO +: 2] != 2'h0); // RULE6
    status_word[STS_GATE_POS] = s.gate;
    status_word[STS_AUTO_POS] = s.auto_closed;
  endfunction : status_word

  ////////////////////////////////////////////////////////////////////////////////
  // State

  ccfm_state_t r;
  ccfm_state_t n;

  logic [3:0]  rise;
  logic        tick;
  logic        sw;
  logic        hw_ok;
  logic        sw_rise;
  logic        hw_rise;
  logic        open_now;
  logic        up;
  logic        wrap;
  ccfm_mode_t  mode;
  ccfm_dir_t   mdir;
  logic        ge;
  logic        le;
  logic        eq;
  logic        dir_ok;
  logic        cond;
  logic        hit;
  logic        in_band;
  logic        leave_up;
  logic        start_pulse;
  logic        clr_ok;
  logic        freq_run;
  logic        period_end;
  logic        acc_first;
  logic        acc_done;

  always_comb begin
    n = r;

    // Input synchronisers and edge detection
    n.s1 = {latch_in, hardware_gate_input, dir_in, pulse_in};
    n.s2 = r.s1;
    n.sp = r.s2;
    rise = r.s2 & ~r.sp; // RULE26

    // Millisecond time base
    tick = (r.pre == PRE_W'(MS_CYCLES - 1));
    n.pre = tick ? '0 : r.pre + 1'b1;

    // Gate control
    sw      = r.ctrl[CTL_SOFTWARE_GATE_BIT];
    hw_ok   = r.ctrl[CTL_HW_EN] ? r.s2[PIN_HWG] : 1'b1; // RULE23
    sw_rise = sw & ~r.sw_prev;
    hw_rise = r.ctrl[CTL_HW_EN] & rise[PIN_HWG];
    n.sw_prev = sw;
    if (hw_rise) begin
      n.hw_rise_seen = 1'b1;
    end
    if (r.auto_closed) begin
      if (r.ctrl[CTL_HW_EN]) begin
        if ((hw_rise && sw) || (sw_rise && r.hw_rise_seen)) begin // RULE2
          n.auto_closed  = 1'b0;
          n.hw_rise_seen = 1'b0;
        end
      end else if (sw_rise) begin
        n.auto_closed = 1'b0;
      end
    end
    open_now = sw & hw_ok & ~r.auto_closed & ~r.ctrl[CTL_FREQ]; // RULE22
    n.gate = open_now;
    if (open_now && !r.gate && !r.ctrl[CTL_STOP_FN]) begin
      n.count = r.load; // Cancel function restarts; stop function keeps the count RULE1
    end

    // Counting
    up   = ~r.s2[PIN_DIR];
    wrap = up ? (r.count == 32'h7FFF_FFFF) : (r.count == 32'h8000_0000);
    if (r.gate && rise[PIN_PULSE] && !r.ctrl[CTL_FREQ]) begin // RULE22
      n.count   = up ? r.count + 1'b1 : r.count - 1'b1;
      n.last_up = up;
      if (wrap && r.ctrl[CTL_SINGLE]) begin
        n.auto_closed  = 1'b1;
        n.hw_rise_seen = 1'b0;
      end
    end

    // Latch, cleared only by reset so it survives a stop-run transition
    if (r.gate && rise[PIN_LATCH]) begin
      n.latch = r.count; // RULE3 RULE4
    end

    // Comparator
    mode     = ccfm_mode_t'(r.ctrl[CTL_MODE_LO +: 2]);
    mdir     = ccfm_dir_t'(r.ctrl[CTL_DIR_LO +: 2]);
    ge       = $signed(r.count) >= $signed(r.cmp); // RULE5
    le       = $signed(r.count) <= $signed(r.cmp);
    eq       = (r.count == r.cmp);
    dir_ok   = (mdir == DIR_ANY) || (mdir == DIR_RSVD) || ((mdir == DIR_UP) == n.last_up);
    cond     = (mode == CMP_GE) ? ge : le;
    hit      = eq & dir_ok; // RULE9
    in_band  = ($signed(r.count) > $signed(r.hyst_lo)) && ($signed(r.count) < $signed(r.hyst_hi));
    leave_up = $signed(r.count) >= $signed(r.hyst_hi);
    start_pulse = 1'b0;

    case (mode)
      CMP_NONE: begin
        n.result   = 1'b0; // RULE6
        n.hyst_act = 1'b0;
      end
      CMP_GE, CMP_LE: begin
        if (!r.hyst_act) begin
          n.result = cond; // RULE7
          if (cond && r.hyst > 8'h01) begin // RULE14
            n.hyst_act = 1'b1; // RULE16
          end
        end else if (!in_band) begin
          n.hyst_act = 1'b0;
          n.result   = cond;
        end
      end
      default: begin
        if (!r.hyst_act) begin
          if ((r.pdur == 8'h00) ? hit : ((n.count != r.count) && (n.count == r.cmp) && dir_ok)) begin // RULE12
            start_pulse = 1'b1;
            n.hyst_up   = n.last_up;
            if (r.hyst > 8'h01) begin // RULE14
              n.hyst_act = 1'b1; // RULE16
            end
          end
        end else if (!in_band) begin
          n.hyst_act = 1'b0;
          if (leave_up != r.hyst_up) begin
            start_pulse = 1'b1; // RULE17
          end
        end
        if (r.pdur == 8'h00) begin
          n.result = r.hyst_act ? (in_band ? r.result : 1'b0) : hit; // RULE10
        end else begin
          n.result = r.pulse_run;
        end
      end
    endcase

    // Band is fixed at activation with the width then in force
    if (n.hyst_act && !r.hyst_act) begin
      n.hyst_lo = r.cmp - {24'h00_0000, r.hyst}; // RULE15
      n.hyst_hi = r.cmp + {24'h00_0000, r.hyst};
    end

    // Pulse timer, counts 1 ms ticks from twice the 2 ms-step duration, captured at start
    if (r.pulse_run && tick) begin
      n.pulse_ms = r.pulse_ms - 1'b1;
      if (r.pulse_ms <= 10'h001) begin
        n.pulse_run = 1'b0;
      end
    end
    if (start_pulse && !r.pulse_run && r.pdur != 8'h00 && mode == CMP_PULSE) begin // RULE12
      n.pulse_run = 1'b1;
      n.pulse_ms  = {1'b0, r.pdur, 1'b0}; // RULE11 RULE13
      n.result    = 1'b1;
    end
    if (mode != CMP_PULSE) begin
      n.pulse_run = 1'b0;
    end

    // Output and compare status
    n.do_out  = (mode == CMP_NONE) ? r.ctrl[CTL_CTRL_DO] : (n.result & r.ctrl[CTL_OUT_EN]); // RULE6 RULE7 RULE9
    n.cmp_irq = n.result & ~r.result & r.ctrl[CTL_CMP_IE] & (mode != CMP_NONE);
    clr_ok    = (mode == CMP_PULSE) ? (!r.pulse_run && !eq) : !cond; // RULE8
    if (r.clr_pend && clr_ok) begin
      n.cmp_flag = 1'b0;
      n.clr_pend = 1'b0;
    end
    if (n.result) begin
      n.cmp_flag = 1'b1;
    end
    if (mode == CMP_NONE) begin
      n.cmp_flag = 1'b0; // RULE6
      n.clr_pend = 1'b0;
    end

    // Frequency measurement, one independent engine per channel
    freq_run   = r.ctrl[CTL_FREQ] & sw; // RULE18 RULE21
    period_end = freq_run && tick && (r.int_ms + 1'b1 >= r.int_len);
    n.meas_irq = 1'b0;
    if (!freq_run) begin
      n.int_ms  = '0;
      n.edges   = ZERO32;
      n.int_len = r.itime;
    end else begin
      if (rise[PIN_PULSE]) begin
        n.edges = r.edges + 1'b1;
      end
      if (tick) begin
        n.int_ms = r.int_ms + 1'b1;
      end
      if (period_end) begin
        n.meas     = freq_mhz(n.edges, r.int_len); // RULE19 RULE20 RULE25
        n.edges    = ZERO32;
        n.int_ms   = '0;
        n.int_len  = r.itime;
        n.meas_irq = r.ctrl[CTL_MEAS_IE]; // RULE24
      end
    end

    // APB slave with one wait state
    acc_first = psel & penable & ~r.pready;
    acc_done  = psel & penable & r.pready;
    n.pready  = acc_first;
    n.pslverr = acc_first & ~addr_known(paddr);
    n.prdata  = ZERO32;
    if (acc_first && !pwrite) begin
      if (paddr == OFS_CTRL) begin
        n.prdata = {19'h0_0000, r.ctrl};
      end else if (paddr == OFS_STATUS) begin
        n.prdata = status_word(r);
      end else if (paddr == OFS_CMP) begin
        n.prdata = r.cmp;
      end else if (paddr == OFS_LOAD) begin
        n.prdata = r.load;
      end else if (paddr == OFS_HYST) begin
        n.prdata = {24'h00_0000, r.hyst};
      end else if (paddr == OFS_PDUR) begin
        n.prdata = {24'h00_0000, r.pdur};
      end else if (paddr == OFS_ITIME) begin
        n.prdata = {18'h0_0000, r.itime};
      end else if (paddr == OFS_COUNT) begin
        n.prdata = r.count;
      end else if (paddr == OFS_LATCH) begin
        n.prdata = r.latch;
      end else if (paddr == OFS_MEAS) begin
        n.prdata = r.meas;
      end
    end
    if (acc_done && pwrite) begin
      if (paddr == OFS_CTRL) begin
        n.ctrl = pwdata[CTL_W-1:0];
      end else if (paddr == OFS_STATUS) begin
        if (pwdata[COMPARE_STATUS_FLAG_POS] && mode != CMP_NONE) begin
          n.clr_pend = 1'b1; // RULE8
        end
      end else if (paddr == OFS_CMP) begin
        n.cmp = pwdata; // RULE5
      end else if (paddr == OFS_LOAD) begin
        n.load = pwdata;
      end else if (paddr == OFS_HYST) begin
        n.hyst = pwdata[7:0]; // RULE14
      end else if (paddr == OFS_PDUR) begin
        n.pdur = pwdata[7:0]; // RULE13
      end else if (paddr == OFS_ITIME) begin
        if (pwdata[13:0] < 14'(ITIME_MS_MIN)) begin
          n.itime = 14'(ITIME_MS_MIN);
        end else if (pwdata[31:14] != 18'h0_0000 || pwdata[13:0] > 14'(ITIME_MS_MAX)) begin
          n.itime = 14'(ITIME_MS_MAX);
        end else begin
          n.itime = pwdata[13:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.ctrl    <= CTRL_RST;
      r.itime   <= ITIME_RST;
      r.int_len <= ITIME_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pready                  = r.pready;
  assign pslverr                 = r.pslverr;
  assign prdata                  = r.prdata;
  assign digital_out             = r.do_out;
  assign output_state_indication = r.do_out;
  assign cmp_irq                 = r.cmp_irq;
  assign meas_irq                = r.meas_irq;

endmodule : ccfm_top

// *** test/ccfm_props.sv ***
// Checker for the count channel top: bus timing, output and event relations.
// Assumes it sees only the top ports; CTRL and PDUR are shadowed from APB writes.
`timescale 1ns/1ps
module ccfm_props
  import ccfm_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        pulse_in,
  input wire logic        dir_in,
  input wire logic        hardware_gate_input,
  input wire logic        latch_in,
  input wire logic        digital_out,
  input wire logic        output_state_indication,
  input wire logic        cmp_irq,
  input wire logic        meas_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [CTL_W-1:0] ctl_r;
  logic [7:0]       pdur_r;
  logic [7:0]       plen_r;
  logic [2:0]       age_r;
  logic [31:0]      hi_r;
  logic [31:0]      gap_r;
  logic             wr;
  assign wr = psel && penable && pready && pwrite;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r  <= CTRL_RST;
      pdur_r <= 8'h00;
      plen_r <= 8'h00;
      age_r  <= 3'h7;
      hi_r   <= 32'h0000_0000;
      gap_r  <= 32'h0000_0000;
    end else begin
      ctl_r  <= (wr && paddr == OFS_CTRL) ? pwdata[CTL_W-1:0] : ctl_r;
      pdur_r <= (wr && paddr == OFS_PDUR) ? pwdata[7:0] : pdur_r;
      age_r  <= (wr && paddr == OFS_CTRL) ? 3'h0 : ((age_r == 3'h7) ? age_r : age_r + 3'h1);
      plen_r <= (digital_out && hi_r == 32'h0000_0000) ? pdur_r : plen_r;
      hi_r   <= digital_out ? hi_r + 32'h0000_0001 : 32'h0000_0000;
      gap_r  <= meas_irq ? 32'h0000_0000 : gap_r + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_one_wait: assert property (s_access |=> s_answer) else $error("pready not one cycle after access");
  a_err_read_zero: assert property (pslverr |-> pready && prdata == ZERO32) else $error("error without pready or data");
  a_state_mirror: assert property (digital_out == output_state_indication) else $error("state differs");
  a_plain_output: assert property (age_r == 3'h7 && ctl_r[5:4] == 2'h0 |->
    digital_out == ctl_r[CTL_CTRL_DO]) else $error("plain output wrong");
  a_out_en_off: assert property (age_r == 3'h7 && ctl_r[5:4] != 2'h0 && !ctl_r[CTL_OUT_EN] |->
    !digital_out) else $error("output set without enable");
  a_pulse_width: assert property ($fell(digital_out) && ctl_r[5:4] == 2'h3 && plen_r != 8'h00 |->
    hi_r >= (2 * plen_r - 1) * MS_CYCLES && hi_r <= 2 * plen_r * MS_CYCLES + 2) else $error("pulse width wrong");
  a_meas_gap: assert property (meas_irq |-> gap_r >= ITIME_MS_MIN * MS_CYCLES - 2)
    else $error("integration period too short");
  a_meas_enable: assert property (meas_irq |-> ctl_r[CTL_MEAS_IE]) else $error("measure event not enabled");
  a_cmp_single: assert property (cmp_irq |-> ctl_r[CTL_CMP_IE] ##1 !cmp_irq) else $error("compare event wrong");
endmodule : ccfm_props

bind ccfm_top ccfm_props #(.MS_CYCLES(MS_CYCLES)) u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .prdata, .pulse_in, .dir_in, .hardware_gate_input, .latch_in, .digital_out,
  .output_state_indication, .cmp_irq, .meas_irq);

// *** test/ccfm_encoder.sv ***
// Field-side encoder model: bursts of count pulses with a direction level.
// Assumes a one-cycle start strobe from the bench; pins change only after edges.
`timescale 1ns/1ps
module ccfm_encoder (
  // Clock
  input  wire logic       pclk,
  // Burst request
  input  wire logic       start,
  input  wire logic [7:0] num,
  input  wire logic       down,
  // Field pins and status
  output logic            pulse_in,
  output logic            dir_in,
  output logic            busy
);
  logic [8:0] half_r;
  logic [1:0] ph_r;
  initial begin
    half_r   = 9'h000;
    ph_r     = 2'h0;
    pulse_in = 1'b0;
    dir_in   = 1'b0;
  end
  assign busy = (half_r != 9'h000);
  // Each level lasts three cycles, so the synchroniser samples it three times
  always @(posedge pclk) begin
    if (start && !busy) begin
      half_r <= {num, 1'b0};
      ph_r   <= 2'h0;
      dir_in <= down;
    end else if (busy) begin
      ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      if (ph_r == 2'h2) begin
        half_r   <= half_r - 9'h001;
        pulse_in <= ~pulse_in;
      end
    end
  end
endmodule : ccfm_encoder

// *** test/test_counter_compare_freq_meter.sv ***
// Testbench for the count channel: registers, gate, latch, comparator, frequency.
// Assumes the encoder model and the bound checker; one ms is 10 cycles here.
`timescale 1ns/1ps
module test_counter_compare_freq_meter;
  import ccfm_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} ccfm_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, c0;
  logic        pready, pslverr, dgo, osi, cmp_irq, meas_irq, pls, dir, busy, err, prev = 1'b0;
  logic        hwg = 1'b0, lat = 1'b0, start = 1'b0, down = 1'b0;
  logic [7:0]  num = 8'h00;
  int          bad_count = 0, compares = 0, rises = 0, r0;
  ccfm_row_t   rows [8] = '{'{OFS_CMP, 32'h1234_5678, 32'h1234_5678, 1'b0},
    '{OFS_HYST, 32'h0000_01FF, 32'h0000_00FF, 1'b0}, '{OFS_PDUR, 32'h0000_0101, 32'h0000_0001, 1'b0},
    '{OFS_ITIME, 32'h0000_0005, 32'h0000_000A, 1'b0}, '{OFS_ITIME, 32'h0000_4E20, 32'h0000_2710, 1'b0},
    '{OFS_LOAD, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{OFS_COUNT, 32'h0000_0055, 32'h0000_0000, 1'b0},
    '{12'h100, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
  ccfm_top #(.MS_CYCLES(10)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .pulse_in(pls), .dir_in(dir), .hardware_gate_input(hwg), .latch_in(lat),
    .digital_out(dgo), .output_state_indication(osi), .cmp_irq, .meas_irq);
  ccfm_encoder u_enc (.pclk, .start, .num, .down, .pulse_in(pls), .dir_in(dir), .busy);
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    prev <= dgo;
    if (dgo === 1'b1 && prev === 1'b0) rises <= rises + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd  = prdata;
    err = pslverr;
    if (n >= 20) bad_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, rd, e);
  endtask : rdc
  task automatic pulses(input logic [7:0] n, input logic dn);
    int k;
    k = 0;
    start <= 1'b1;
    num   <= n;
    down  <= dn;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 3000) bad_count++;
    cyc(6);
  endtask : pulses
  task automatic wait_meas;
    int k;
    k = 0;
    @(posedge pclk);
    while (meas_irq !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) bad_count++;
  endtask : wait_meas
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #3_000_000;
    bad_count++;
    end_sim();
  end
  initial begin
    cyc(3);
    presetn <= 1'b1;
    rdc("ctrl_reset", OFS_CTRL, {19'h0_0000, CTRL_RST});
    rdc("itime_reset", OFS_ITIME, {18'h0_0000, ITIME_RST});
    chk("out_reset", {31'h0000_0000, dgo}, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc("reg_readback", rows[i].a, rows[i].q);
      chk("reg_error", {31'h0000_0000, err}, {31'h0000_0000, rows[i].e});
    end
    wr(OFS_CMP, 32'h0000_000A);
    wr(OFS_HYST, 32'h0000_0000);
    wr(OFS_ITIME, 32'h0000_000A);
    hwg <= 1'b1;
    cyc(4);
    wr(OFS_CTRL, 32'h0000_1107);
    pulses(8'h05, 1'b0);
    rdc("count_open", OFS_COUNT, 32'h0000_0005);
    lat <= 1'b1;
    cyc(3);
    lat <= 1'b0;
    cyc(6);
    rdc("latch", OFS_LATCH, 32'h0000_0005);
    hwg <= 1'b0;
    cyc(6);
    pulses(8'h02, 1'b0);
    rdc("count_closed", OFS_COUNT, 32'h0000_0005);
    hwg <= 1'b1;
    cyc(6);
    pulses(8'h03, 1'b0);
    rdc("count_resume", OFS_COUNT, 32'h0000_0008);
    rdc("latch_kept", OFS_LATCH, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0000_1307);
    cyc(4);
    chk("plain_out", {31'h0000_0000, dgo}, 32'h0000_0001);
    rdc("plain_status", OFS_STATUS, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_1117);
    pulses(8'h02, 1'b0);
    chk("ge_out", {31'h0000_0000, dgo}, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0001);
    rdc("clear_held", OFS_STATUS, 32'h0000_0007);
    wr(OFS_CTRL, 32'h0000_1017);
    cyc(4);
    chk("ge_no_enable", {31'h0000_0000, dgo}, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_1117);
    pulses(8'h01, 1'b1);
    chk("ge_left", {31'h0000_0000, dgo}, 32'h0000_0000);
    rdc("clear_done", OFS_STATUS, 32'h0000_0004);
    wr(OFS_PDUR, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_1137);
    r0 = rises;
    pulses(8'h01, 1'b0);
    pulses(8'h01, 1'b1);
    pulses(8'h01, 1'b0);
    cyc(20);
    chk("pulse_end", {31'h0000_0000, dgo}, 32'h0000_0000);
    chk("pulse_once", rises - r0, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_11B7);
    r0 = rises;
    pulses(8'h01, 1'b1);
    pulses(8'h01, 1'b0);
    chk("dir_up_hit", rises - r0, 32'h0000_0000);
    pulses(8'h01, 1'b0);
    pulses(8'h01, 1'b1);
    chk("dir_down_hit", rises - r0, 32'h0000_0001);
    cyc(50);
    wr(OFS_PDUR, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_1137);
    cyc(4);
    chk("level_pulse", {31'h0000_0000, dgo}, 32'h0000_0001);
    pulses(8'h01, 1'b1);
    chk("level_left", {31'h0000_0000, dgo}, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_000A);
    wr(OFS_LOAD, 32'h7FFF_FFFE);
    wr(OFS_CTRL, 32'h0000_000B);
    pulses(8'h02, 1'b0);
    rdc("auto_close", OFS_STATUS, 32'h0000_0008);
    hwg <= 1'b0;
    cyc(6);
    hwg <= 1'b1;
    cyc(6);
    rdc("reopen", OFS_STATUS, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0C01);
    apb(OFS_COUNT, 1'b0, 32'h0000_0000);
    c0 = rd;
    wait_meas();
    pulses(8'h04, 1'b0);
    wait_meas();
    rdc("freq_value", OFS_MEAS, 32'h0006_1A80);
    wait_meas();
    rdc("freq_zero", OFS_MEAS, 32'h0000_0000);
    rdc("freq_no_count", OFS_COUNT, c0);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rdc("itime_rerun", OFS_ITIME, {18'h0_0000, ITIME_RST});
    rdc("latch_rerun", OFS_LATCH, 32'h0000_0000);
    end_sim();
  end
endmodule : test_counter_compare_freq_meter
